/* rtl/isl_slave_engine.sv */
/*
  Two-wire slave engine with AHB-Lite register slave: address match,
  byte receive and transmit through one data buffer, clock stretching,
  general call handling and sticky write-one-to-clear status.
  Assumes external open-drain wiring of scl and sda and a single AHB master.
*/
`timescale 1ns/1ps

// How it works
// - when enabled, catch start, take 8 bits, match own or general call, ACK.
// - idle in slave receive; watch addresses only while unit_enable is set.
// - read/write bit low keeps receiving, high switches to transmitting.
// - on a match set slave_address_detected once the address is acknowledged.
// - receive 8 bits, after acknowledge copy to buffer and set receive full.
// - as receiver pull data low for acknowledge, ack_select picks ACK or NAK.
// - transmit empty with transfer_byte clear interrupts; software loads, sets.
// - as transmitter release data during the acknowledge bit.
// - hold clock low with no transmit byte or an unread received byte.
// - stop ending a slave transfer sets stop_detected and clears unit_busy.
// - status flags clear when software writes one to them.
// - general call with disable clear sets both detect flags.
// - general call disable set means general call is ignored entirely.
// - second byte 0x06 resets and loads address part, 0x04 loads only.
// - hardware general call, ten-bit addresses and CBUS are not supported.
// - reset returns to defaults, own address register included.
// - glitches up to four clock periods on bus inputs are filtered.
// - unit_reset resets interface logic and the unit and bus busy status bits, leaving other mapped bits intact.
module isl_slave_engine (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [isl_pkg::PROG_BITS-1:0] prog_addr,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic irq
);
  import isl_pkg::*;

  // reset release through two flops
  logic [1:0] rst_sync_ff;
  logic rst_n;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // line filters, bit 0 clock and bit 1 data
  logic [1:0] line_raw;
  logic [1:0] line_flt;
  assign line_raw = {sda_i, scl_i};
  for (genvar g = 0; g < 2; g++) begin : g_flt
    isl_line_filter u_flt (
      .clk(clk),
      .rst_n(rst_n),
      .line_i(line_raw[g]),
      .line_o(line_flt[g])
    );
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  isl_bus_cond u_cond (
    .clk(clk),
    .rst_n(rst_n),
    .scl(line_flt[0]),
    .sda(line_flt[1]),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det)
  );

  // register state
  logic [7:0] data_ff, nxt_data;
  logic [15:0] ctl_ff, nxt_ctl;
  logic [6:0] own_ff, nxt_own;
  logic sad_ff, general_call_detected_ff, rf_ff, te_ff, ssd_ff;
  logic nxt_sad, nxt_general_call_detected, nxt_rf, nxt_te, nxt_ssd;
  logic rwm_ff, ackst_ff, ub_ff, bb_ff, unread_ff;
  logic nxt_rwm, nxt_ackst, nxt_ub, nxt_bb, nxt_unread;

  // engine state
  isl_state_t state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] shift_ff, nxt_shift;
  logic sda_oe_ff, nxt_sda_oe;
  logic gc_ff, nxt_gc;

  // bus slave state
  logic wr_pend_ff, nxt_wr_pend;
  logic rd_pend_ff, nxt_rd_pend;
  logic [7:0] addr_ff, nxt_addr;
  logic [31:0] hrdata_ff, nxt_hrdata;

  // engine events towards the register group
  logic ev_sad, ev_rf, ev_te, ev_ssd, ev_tb_clr, ev_ack, ack_val;
  logic gc_reset, gc_load;

  logic en, tb, general_call_disable, ureset, own_hit, gc_hit;
  assign en = ctl_ff[CTL_UNIT_ENABLE];
  assign tb = ctl_ff[CTL_TRANSFER_BYTE];
  assign general_call_disable = ctl_ff[CTL_GC_DISABLE];
  assign ureset = ctl_ff[CTL_UNIT_RESET];
  // general call never hits the own-address path, so disable is total
  assign gc_hit = shift_ff == {GC_ADDR, 1'b0} && !general_call_disable;
  assign own_hit = shift_ff[7:1] == own_ff && shift_ff[7:1] != GC_ADDR;

  function automatic logic [31:0] stat_word(input logic [9:0] f);
    stat_word = {22'h000000, f};
  endfunction

  // byte engine: bits are sampled on clock rise, driven after clock fall
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_gc = gc_ff;
    ev_sad = 1'b0;
    ev_rf = 1'b0;
    ev_te = 1'b0;
    ev_ssd = 1'b0;
    ev_tb_clr = 1'b0;
    ev_ack = 1'b0;
    ack_val = 1'b0;
    gc_reset = 1'b0;
    gc_load = 1'b0;
    if (ureset || !en) begin
      nxt_state = S_IDLE;
      nxt_sda_oe = 1'b0;
      nxt_gc = 1'b0;
    end else if (start_det) begin
      nxt_state = S_ADDR;
      nxt_cnt = 4'h0;
      nxt_sda_oe = 1'b0;
      nxt_gc = 1'b0;
    end else if (stop_det) begin
      nxt_state = S_IDLE;
      nxt_sda_oe = 1'b0;
      ev_ssd = ub_ff;
    end else begin
      case (state_ff)
        S_ADDR: begin
          if (scl_rise) begin
            nxt_shift = {shift_ff[6:0], line_flt[1]};
            nxt_cnt = cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == BITS_PER_BYTE) begin
            if (own_hit || gc_hit) begin
              nxt_state = S_ADDR_ACK;
              nxt_sda_oe = 1'b1;
              nxt_gc = gc_hit;
            end else begin
              nxt_state = S_IDLE;
            end
          end
        end
        S_ADDR_ACK: begin
          if (scl_fall) begin
            nxt_sda_oe = 1'b0;
            ev_sad = 1'b1;
            if (shift_ff[0]) begin
              nxt_state = S_TX_WAIT;
              ev_te = 1'b1;
            end else begin
              nxt_state = S_RX_WAIT;
            end
          end
        end
        S_RX_WAIT: begin
          // wait for software to read and hand the byte slot back
          if (tb && !unread_ff) begin
            ev_tb_clr = 1'b1;
            nxt_state = S_RX_DATA;
            nxt_cnt = 4'h0;
          end
        end
        S_RX_DATA: begin
          if (scl_rise) begin
            nxt_shift = {shift_ff[6:0], line_flt[1]};
            nxt_cnt = cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == BITS_PER_BYTE) begin
            nxt_state = S_RX_ACK;
            nxt_sda_oe = !ctl_ff[CTL_ACK_SELECT];
            ev_ack = 1'b1;
            ack_val = ctl_ff[CTL_ACK_SELECT];
          end
        end
        S_RX_ACK: begin
          if (scl_fall) begin
            nxt_sda_oe = 1'b0;
            ev_rf = 1'b1;
            nxt_state = S_RX_WAIT;
            nxt_gc = 1'b0;
            // only the byte right after a general call carries a command;
            // odd values (hardware call) and other codes are ignored
            if (gc_ff && !shift_ff[0]) begin
              if (shift_ff == GC_RESET) begin
                gc_reset = 1'b1;
                nxt_state = S_IDLE;
              end else if (shift_ff == GC_LOAD) begin
                gc_load = 1'b1;
              end
            end
          end
        end
        S_TX_WAIT: begin
          if (tb) begin
            ev_tb_clr = 1'b1;
            nxt_shift = data_ff;
            nxt_sda_oe = !data_ff[7];
            nxt_cnt = 4'h0;
            nxt_state = S_TX_DATA;
          end
        end
        S_TX_DATA: begin
          if (scl_fall) begin
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff == TX_LAST_BIT) begin
              nxt_state = S_TX_ACK;
              nxt_sda_oe = 1'b0;
            end else begin
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_sda_oe = !shift_ff[6];
            end
          end
        end
        S_TX_ACK: begin
          if (scl_rise) begin
            ev_ack = 1'b1;
            ack_val = line_flt[1];
          end else if (scl_fall) begin
            ev_te = 1'b1;
            nxt_state = ackst_ff ? S_IDLE : S_TX_WAIT;
          end
        end
        default: begin
          nxt_state = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= S_IDLE;
      cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      sda_oe_ff <= 1'b0;
      gc_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      sda_oe_ff <= nxt_sda_oe;
      gc_ff <= nxt_gc;
    end
  end

  // bus slave: zero-wait writes, reads take one wait state so that
  // the data read already holds the effect of a write just before it
  logic accept;
  assign accept = hsel && htrans[1] && hready;
  always_comb begin
    nxt_wr_pend = accept && hwrite;
    nxt_rd_pend = accept && !hwrite;
    nxt_addr = accept ? haddr[7:0] : addr_ff;
    nxt_hrdata = hrdata_ff;
    if (rd_pend_ff) begin
      case (addr_ff)
        OFS_DATA: nxt_hrdata = {24'h000000, data_ff};
        OFS_CTL: nxt_hrdata = {16'h0000, ctl_ff};
        OFS_STAT: nxt_hrdata = stat_word({sad_ff, general_call_detected_ff, rf_ff, te_ff,
          1'b0, ssd_ff, bb_ff, ub_ff, ackst_ff, rwm_ff});
        OFS_OWN: nxt_hrdata = {25'h0000000, own_ff};
        default: nxt_hrdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff <= 8'h00;
      hrdata_ff <= 32'h00000000;
    end else begin
      wr_pend_ff <= nxt_wr_pend;
      rd_pend_ff <= nxt_rd_pend;
      addr_ff <= nxt_addr;
      hrdata_ff <= nxt_hrdata;
    end
  end

  // registers and sticky flags; a hardware set beats a software clear
  logic [31:0] w1c;
  logic wr_ctl, wr_data, wr_own, rd_data;
  always_comb begin
    wr_ctl = wr_pend_ff && addr_ff == OFS_CTL;
    wr_data = wr_pend_ff && addr_ff == OFS_DATA;
    wr_own = wr_pend_ff && addr_ff == OFS_OWN;
    rd_data = rd_pend_ff && addr_ff == OFS_DATA;
    w1c = (wr_pend_ff && addr_ff == OFS_STAT) ? hwdata : 32'h00000000;
    nxt_sad = ev_sad | (sad_ff & ~w1c[ST_SAD]);
    nxt_general_call_detected = (ev_sad & gc_ff) | (general_call_detected_ff & ~w1c[ST_GENERAL_CALL_DETECTED]);
    nxt_rf = ev_rf | (rf_ff & ~w1c[ST_RF]);
    nxt_te = ev_te | (te_ff & ~w1c[ST_TE]);
    nxt_ssd = ev_ssd | (ssd_ff & ~w1c[ST_SSD]);
    nxt_rwm = ev_sad ? shift_ff[0] : rwm_ff;
    nxt_ackst = ev_ack ? ack_val : ackst_ff;
    nxt_ub = (ub_ff | ev_sad) & ~stop_det & ~ureset;
    nxt_bb = (bb_ff | start_det) & ~stop_det & ~ureset;
    // unread tracks the byte software has not fetched yet
    nxt_unread = (ev_rf | (unread_ff & ~rd_data)) & ~ureset;
    nxt_data = ev_rf ? shift_ff : (wr_data ? hwdata[7:0] : data_ff);
    nxt_ctl = ctl_ff;
    if (ev_tb_clr) begin
      nxt_ctl[CTL_TRANSFER_BYTE] = 1'b0;
    end
    if (wr_ctl) begin
      nxt_ctl = hwdata[15:0];
    end
    nxt_own = wr_own ? hwdata[6:0] : own_ff;
    if (gc_load || gc_reset) begin
      nxt_own[PROG_BITS-1:0] = prog_addr;
    end
    if (gc_reset) begin
      // everything but the own address returns to reset values
      nxt_ctl = CTL_RST;
      nxt_data = 8'h00;
      nxt_sad = 1'b0;
      nxt_general_call_detected = 1'b0;
      nxt_rf = 1'b0;
      nxt_te = 1'b0;
      nxt_ssd = 1'b0;
      nxt_rwm = 1'b0;
      nxt_ackst = 1'b0;
      nxt_ub = 1'b0;
      nxt_bb = 1'b0;
      nxt_unread = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_ff <= 8'h00;
      ctl_ff <= CTL_RST;
      own_ff <= OWN_RST;
      {sad_ff, general_call_detected_ff, rf_ff, te_ff, ssd_ff} <= 5'h00;
      {rwm_ff, ackst_ff, ub_ff, bb_ff, unread_ff} <= 5'h00;
    end else begin
      data_ff <= nxt_data;
      ctl_ff <= nxt_ctl;
      own_ff <= nxt_own;
      {sad_ff, general_call_detected_ff, rf_ff, te_ff, ssd_ff} <=
        {nxt_sad, nxt_general_call_detected, nxt_rf, nxt_te, nxt_ssd};
      {rwm_ff, ackst_ff, ub_ff, bb_ff, unread_ff} <=
        {nxt_rwm, nxt_ackst, nxt_ub, nxt_bb, nxt_unread};
    end
  end

  // stretching: clock held low until software services the buffer
  assign scl_oe = (state_ff == S_RX_WAIT && (!tb || unread_ff)) ||
    (state_ff == S_TX_WAIT && !tb);
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_ff;
  assign irq = (sad_ff & ctl_ff[CTL_SAD_IE]) | (rf_ff & ctl_ff[CTL_RF_IE]) |
    (te_ff & ~tb & ctl_ff[CTL_TE_IE]) | (ssd_ff & ctl_ff[CTL_SSD_IE]);
  assign hreadyout = !rd_pend_ff;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_addr_ack_drive: assert property (
    state_ff == S_ADDR_ACK |-> sda_oe && $past(state_ff) != S_IDLE)
    else $error("address acknowledge not driven");
  a_disabled_idle: assert property (
    !en && !$past(en) |-> state_ff == S_IDLE && !sda_oe)
    else $error("engine active while disabled");
  a_mode_select: assert property (
    state_ff == S_ADDR_ACK && scl_fall && en && !ureset && !start_det &&
    !stop_det |=> state_ff == ($past(shift_ff[0]) ? S_TX_WAIT : S_RX_WAIT))
    else $error("wrong mode after address");
  a_rx_copy: assert property (
    state_ff == S_RX_ACK && ev_rf && !gc_ff |=>
    rf_ff && unread_ff && data_ff == $past(shift_ff))
    else $error("received byte not copied");
  a_rx_ack_select: assert property (
    $rose(sda_oe) && $past(state_ff) == S_RX_DATA |->
    !$past(ctl_ff[CTL_ACK_SELECT]))
    else $error("acknowledge ignores ack_select");
  a_tx_ack_release: assert property (
    state_ff == S_TX_ACK |-> !sda_oe)
    else $error("data driven during master acknowledge");
  a_stretch_tx: assert property (
    state_ff == S_TX_WAIT && !tb |-> scl_oe [*2] or ##1 state_ff != S_TX_WAIT
    or ##1 tb)
    else $error("clock released with no transmit byte");
  a_stop_flag: assert property (
    stop_det && ub_ff && en && !ureset && !start_det |=> ssd_ff && !ub_ff)
    else $error("stop not recorded");
  a_gc_ignored: assert property (
    state_ff == S_ADDR && scl_fall && cnt_ff == BITS_PER_BYTE &&
    shift_ff == 8'h00 && general_call_disable && en && !ureset && !start_det && !stop_det
    |=> state_ff == S_IDLE && !sda_oe)
    else $error("general call answered while disabled");
  a_irq_sad: assert property (
    sad_ff && ctl_ff[CTL_SAD_IE] |-> irq)
    else $error("enabled address flag gives no interrupt");
endmodule

/* rtl/isl_pkg.sv */
/*
  Shared constants for the two-wire slave engine: register offsets, field
  positions, reset values, general call codes, filter timing and states.
  Assumes a 20 MHz system clock and 32-bit word-aligned register access.
*/
package isl_pkg;

  // system clock
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned CLK_NS = 1000 / CLK_MHZ;

  // glitch filter: pulses up to this many input clocks are swallowed
  localparam int unsigned GLITCH_PERIODS = 4;
  localparam int unsigned FILTER_CYC = GLITCH_PERIODS + 1;
  localparam logic [2:0] FILTER_LAST = 3'(FILTER_CYC - 1);

  // register byte offsets
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_CTL = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_OWN = 8'h0C;

  // bus_control_reg fields
  localparam int unsigned CTL_ACK_SELECT = 2;
  localparam int unsigned CTL_TRANSFER_BYTE = 3;
  localparam int unsigned CTL_UNIT_ENABLE = 6;
  localparam int unsigned CTL_GC_DISABLE = 7;
  localparam int unsigned CTL_TE_IE = 8;
  localparam int unsigned CTL_RF_IE = 9;
  localparam int unsigned CTL_SSD_IE = 11;
  localparam int unsigned CTL_SAD_IE = 13;
  localparam int unsigned CTL_UNIT_RESET = 14;
  localparam logic [15:0] CTL_RST = 16'h0000;

  // bus_status_reg fields
  localparam int unsigned ST_RWM = 0;
  localparam int unsigned ST_ACK = 1;
  localparam int unsigned ST_UB = 2;
  localparam int unsigned ST_BB = 3;
  localparam int unsigned ST_SSD = 4;
  localparam int unsigned ST_TE = 6;
  localparam int unsigned ST_RF = 7;
  localparam int unsigned ST_GENERAL_CALL_DETECTED = 8;
  localparam int unsigned ST_SAD = 9;

  // own slave address and its programmable low part
  localparam logic [6:0] OWN_RST = 7'h00;
  localparam int unsigned PROG_BITS = 3;

  // general call codes
  localparam logic [6:0] GC_ADDR = 7'h00;
  localparam logic [7:0] GC_RESET = 8'h06;
  localparam logic [7:0] GC_LOAD = 8'h04;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] TX_LAST_BIT = 4'h7;

  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ADDR_ACK, S_RX_WAIT, S_RX_DATA, S_RX_ACK,
    S_TX_WAIT, S_TX_DATA, S_TX_ACK
  } isl_state_t;

endpackage

/* rtl/isl_line_filter.sv */
/*
  One bus line input: three-flop synchroniser followed by a glitch filter.
  Assumes the line is asynchronous to clk and idles high.
*/
`timescale 1ns/1ps
module isl_line_filter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic line_i,
  output logic line_o
);
  import isl_pkg::*;

  logic [2:0] sync_ff;
  logic [2:0] nxt_sync;
  logic out_ff;
  logic nxt_out;
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;

  // new level must hold FILTER_CYC clocks before it is believed
  always_comb begin
    nxt_sync = {sync_ff[1:0], line_i};
    nxt_out = out_ff;
    nxt_cnt = 3'h0;
    if (sync_ff[1] == sync_ff[2] && sync_ff[2] != out_ff) begin
      if (cnt_ff == FILTER_LAST) begin
        nxt_out = sync_ff[2];
      end else begin
        nxt_cnt = cnt_ff + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_ff <= 3'h7;
      out_ff <= 1'b1;
      cnt_ff <= 3'h0;
    end else begin
      sync_ff <= nxt_sync;
      out_ff <= nxt_out;
      cnt_ff <= nxt_cnt;
    end
  end

  assign line_o = out_ff;
endmodule

/* rtl/isl_bus_cond.sv */
/*
  Bus condition detector: clock edges, start and stop, from filtered lines.
  Assumes both inputs are already clean and in the clk domain.
*/
`timescale 1ns/1ps
module isl_bus_cond (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_det,
  output logic stop_det
);
  logic scl_ff;
  logic sda_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
    end else begin
      scl_ff <= scl;
      sda_ff <= sda;
    end
  end

  // data moving while clock stays high marks start or stop
  assign scl_rise = scl & ~scl_ff;
  assign scl_fall = ~scl & scl_ff;
  assign start_det = scl & scl_ff & sda_ff & ~sda;
  assign stop_det = scl & scl_ff & ~sda_ff & sda;
endmodule

/* verification/isl_master_model.sv */
/*
  Behavioural two-wire bus master used as the far side of the slave engine.
  Assumes the bench does the open-drain wiring: 1 on an output = released.
*/
`timescale 1ns/1ps
module isl_master_model (
  input wire logic scl_line,
  input wire logic sda_line,
  output logic scl_rel,
  output logic sda_rel
);
  int stuck = 0;

  // both lines released, so the pull-ups hold the idle level
  initial begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
  end

  // release clock, wait out stretching; bounded so a stuck bus is counted
  task automatic rise();
    int n;
    scl_rel = 1'b1;
    n = 0;
    while (scl_line !== 1'b1 && n < 400) begin
      #50;
      n++;
    end
    if (n == 400) stuck++;
  endtask

  // one bit; the low phase outlasts the slave's sync, filter and drive delay
  task automatic pulse(input logic b, output logic s);
    #100 sda_rel = b;
    #500 rise();
    #300 s = sda_line;
    #100 scl_rel = 1'b0;
  endtask

  // entry offsets keep line changes off the system clock edges
  task automatic start_c();
    #10 sda_rel = 1'b0;
    #400 scl_rel = 1'b0;
  endtask

  task automatic stop_c();
    #110 sda_rel = 1'b0;
    #300 rise();
    #400 sda_rel = 1'b1;
    #400;
  endtask

  // short clock spike, below the filter length
  task automatic glitch();
    #110 scl_rel = 1'b1;
    #150 scl_rel = 1'b0;
  endtask

  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    #10;
    for (int i = 7; i >= 0; i--) pulse(d[i], s);
    pulse(1'b1, s);
    ack = ~s;
  endtask

  // ackline is the sda level seen while the master answers
  task automatic recv(input logic nak, output logic [7:0] d,
                      output logic ackline);
    #10;
    for (int i = 7; i >= 0; i--) pulse(1'b1, d[i]);
    pulse(nak, ackline);
  endtask
endmodule

/* verification/test_isl_slave_engine.sv */
/*
  Self-checking bench for the slave engine: AHB-Lite software side plus
  a behavioural bus master. Assumes open-drain wiring with pull-ups.
*/
`timescale 1ns/1ps
module test_isl_slave_engine;
  import isl_pkg::*;
  localparam logic [31:0] SM = 32'h0000_03D5;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [2:0] prog_addr = 3'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] seed = 32'hCA49;
  logic [31:0] rd, hrdata, base;
  logic hreadyout, hresp, scl_o, scl_oe, sda_o, sda_oe, irq;
  logic scl_rel, sda_rel, ack, al;
  logic [6:0] own;
  logic [7:0] d;
  int errors = 0;
  int check_count = 0;
  // wired-AND of both parties on each line
  wire logic scl_w = scl_rel & (~scl_oe | scl_o);
  wire logic sda_w = sda_rel & (~sda_oe | sda_o);

  isl_slave_engine u_isl_slave_engine (.clk(clk), .rstn(rstn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .prog_addr(prog_addr), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
  isl_master_model u_isl_master_model (.scl_line(scl_w), .sda_line(sda_w),
    .scl_rel(scl_rel), .sda_rel(sda_rel));

  initial begin
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  function automatic logic [31:0] f(input int unsigned p);
    return 32'h1 << p;
  endfunction

  task automatic finish_test();
    if (errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    check_count++;
    if (got !== exp) begin
      $display("wrong value at %0t: %s", $time, m);
      errors++;
    end
  endtask

  // one AHB transfer; ready and read data sampled before the edge
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    logic r;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    for (int p = 0; p < 2; p++) begin
      n = 0;
      r = 1'b0;
      while (r !== 1'b1) begin
        @(negedge clk);
        r = hreadyout;
        rd = hrdata;
        @(posedge clk);
        n++;
        if (n > 20) begin
          errors++;
          finish_test();
        end
      end
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
    end
  endtask

  task automatic stat(input logic [31:0] e, input string m);
    ahb(1'b0, OFS_STAT, 32'h0);
    chk(rd & SM, e, m);
    chk(hresp, 32'h0, "error response");
  endtask

  // bounded wait for the interrupt line
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 200) begin
        errors++;
        finish_test();
      end
    end
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    seed = xs(seed);
    own = 7'h40 | seed[6:0];
    prog_addr <= seed[9:7];
    d = seed[17:10];
    base = f(CTL_UNIT_ENABLE) | f(CTL_SAD_IE) | f(CTL_RF_IE) |
      f(CTL_SSD_IE) | f(CTL_TE_IE);
    // defaults after reset
    chk(irq, 1'b0, "irq at reset");
    stat(32'h0, "status reset");
    ahb(1'b0, OFS_OWN, 32'h0);
    chk(rd, 32'h0, "own reset");
    ahb(1'b0, OFS_CTL, 32'h0);
    chk(rd, 32'h0, "ctl reset");
    ahb(1'b1, OFS_OWN, {25'h0, own});
    ahb(1'b1, OFS_CTL, base);
    // foreign address is not acknowledged
    u_isl_master_model.start_c();
    u_isl_master_model.send({own ^ 7'h01, 1'b0}, ack);
    chk(ack, 1'b0, "foreign ack");
    u_isl_master_model.stop_c();
    stat(32'h0, "foreign status");
    // write: clock spike in the address, then ACK and NAK bytes
    u_isl_master_model.start_c();
    u_isl_master_model.glitch();
    u_isl_master_model.send({own, 1'b0}, ack);
    chk(ack, 1'b1, "address ack");
    wait_irq();
    chk(scl_oe, 1'b1, "stretch after address");
    stat(f(ST_SAD) | f(ST_UB), "write address");
    ahb(1'b1, OFS_STAT, f(ST_SAD));
    @(negedge clk);
    chk(irq, 1'b0, "irq after clear");
    ahb(1'b1, OFS_CTL, base | f(CTL_TRANSFER_BYTE));
    u_isl_master_model.send(d, ack);
    chk(ack, 1'b1, "data ack");
    wait_irq();
    chk(scl_oe, 1'b1, "stretch when full");
    stat(f(ST_RF) | f(ST_UB), "receive full");
    ahb(1'b0, OFS_DATA, 32'h0);
    chk(rd, {24'h0, d}, "received byte");
    ahb(1'b1, OFS_STAT, f(ST_RF));
    ahb(1'b1, OFS_CTL, base | f(CTL_TRANSFER_BYTE) | f(CTL_ACK_SELECT));
    u_isl_master_model.send(~d, ack);
    chk(ack, 1'b0, "nak select");
    wait_irq();
    ahb(1'b0, OFS_DATA, 32'h0);
    chk(rd, {24'h0, ~d}, "second byte");
    ahb(1'b1, OFS_STAT, f(ST_RF));
    ahb(1'b1, OFS_CTL, base | f(CTL_TRANSFER_BYTE));
    u_isl_master_model.stop_c();
    wait_irq();
    stat(f(ST_SSD), "stop after write");
    ahb(1'b1, OFS_STAT, f(ST_SSD));
    stat(32'h0, "stop cleared");
    // read: software loads a random byte, master answers NAK
    seed = xs(seed);
    u_isl_master_model.start_c();
    u_isl_master_model.send({own, 1'b1}, ack);
    chk(ack, 1'b1, "read address ack");
    wait_irq();
    stat(f(ST_SAD) | f(ST_UB) | f(ST_RWM) | f(ST_TE), "read addr");
    ahb(1'b1, OFS_STAT, f(ST_SAD) | f(ST_TE));
    ahb(1'b1, OFS_DATA, {24'h0, seed[7:0]});
    ahb(1'b1, OFS_CTL, base | f(CTL_TRANSFER_BYTE));
    u_isl_master_model.recv(1'b1, d, al);
    chk(d, seed[7:0], "sent byte");
    chk(al, 1'b1, "sda free at ack");
    repeat (20) @(negedge clk);
    ahb(1'b1, OFS_STAT, f(ST_TE));
    u_isl_master_model.stop_c();
    wait_irq();
    // direction bit keeps the last addressed transfer's value
    stat(f(ST_SSD) | f(ST_RWM), "stop after read");
    ahb(1'b1, OFS_STAT, 32'h0000_03D0);
    // general call ignored, then taken with the load code
    ahb(1'b1, OFS_CTL, base | f(CTL_GC_DISABLE));
    u_isl_master_model.start_c();
    u_isl_master_model.send(8'h00, ack);
    chk(ack, 1'b0, "gc while disabled");
    u_isl_master_model.stop_c();
    stat(f(ST_RWM), "gc ignored");
    ahb(1'b1, OFS_CTL, base);
    u_isl_master_model.start_c();
    u_isl_master_model.send(8'h00, ack);
    chk(ack, 1'b1, "gc ack");
    wait_irq();
    stat(f(ST_GENERAL_CALL_DETECTED) | f(ST_SAD) | f(ST_UB), "gc flags");
    ahb(1'b1, OFS_STAT, 32'h0000_03D0);
    ahb(1'b1, OFS_CTL, base | f(CTL_TRANSFER_BYTE));
    u_isl_master_model.send(GC_LOAD, ack);
    chk(ack, 1'b1, "gc second ack");
    repeat (20) @(negedge clk);
    ahb(1'b0, OFS_DATA, 32'h0);
    ahb(1'b1, OFS_CTL, base | f(CTL_TRANSFER_BYTE));
    u_isl_master_model.stop_c();
    ahb(1'b0, OFS_OWN, 32'h0);
    chk(rd, {25'h0, own[6:3], prog_addr}, "gc load");
    // reset code: registers back to defaults, own takes new low part
    ahb(1'b1, OFS_STAT, 32'h0000_03D0);
    prog_addr <= ~prog_addr;
    u_isl_master_model.start_c();
    u_isl_master_model.send(8'h00, ack);
    wait_irq();
    ahb(1'b1, OFS_CTL, base | f(CTL_TRANSFER_BYTE));
    u_isl_master_model.send(GC_RESET, ack);
    chk(ack, 1'b1, "gc reset ack");
    u_isl_master_model.stop_c();
    ahb(1'b0, OFS_CTL, 32'h0);
    chk(rd, 32'h0, "gc reset ctl");
    ahb(1'b0, OFS_OWN, 32'h0);
    chk(rd, {25'h0, own[6:3], prog_addr}, "gc reset own");
    // unit reset keeps the control and own address registers
    ahb(1'b1, OFS_CTL, f(CTL_UNIT_RESET));
    ahb(1'b0, OFS_CTL, 32'h0);
    chk(rd, f(CTL_UNIT_RESET), "ctl kept");
    ahb(1'b0, OFS_OWN, 32'h0);
    chk(rd, {25'h0, own[6:3], prog_addr}, "own kept");
    ahb(1'b1, OFS_STAT, 32'h0000_03D0);
    ahb(1'b1, OFS_CTL, 32'h0);
    chk(u_isl_master_model.stuck, 32'h0, "bus hang");
    finish_test();
  end
endmodule
